// ---- bfsc_cycgen.sv ----
`timescale 1ns/1ps
module bfsc_cycgen import bfsc_pkg::*; #(
  parameter int PW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          sync_lvl,
  input  wire logic [PW-1:0] rt_period,
  output logic               cyc_start,
  output logic               ext_mode,
  output logic               fallback,
  output logic               pin_drive
);

  bfsc_mode_t    mode_reg;
  bfsc_mode_t    mode_next;
  logic          sync_d_reg;
  logic [PW-1:0] cnt_reg;
  logic [PW-1:0] cnt_next;
  logic [PW-1:0] loss_reg;
  logic [PW-1:0] loss_next;
  logic [7:0]    fbp_reg;
  logic [7:0]    fbp_next;

  wire           sync_rise  = sync_lvl & ~sync_d_reg;
  wire           sync_fall  = ~sync_lvl & sync_d_reg;
  wire [PW-1:0]  period_sel = (mode_reg == M_FALLBK) ? PW'(FALLBACK_CYC) : rt_period;
  wire           per_hit    = (cnt_reg + 1'b1) >= period_sel;
  wire           lost       = loss_reg >= PW'(SYNC_LOSS_CYC);
  wire           fb_done    = per_hit && (fbp_reg == 8'(FALLBACK_PULSES - 1));
  wire           cyc_next   = (mode_reg == M_EXT) ? sync_fall : per_hit;

  // External clock wins over the resistor oscillator once seen
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      M_RT:     if (sync_rise) mode_next = M_EXT;
      M_EXT:    if (lost) mode_next = M_FALLBK;
      M_FALLBK: begin
        if (sync_rise) mode_next = M_EXT;
        else if (fb_done) mode_next = M_RT;
      end
      default:  mode_next = M_RT;
    endcase
  end

  assign cnt_next  = (mode_reg == M_EXT || per_hit) ? '0 : cnt_reg + 1'b1;
  assign loss_next = (mode_reg == M_EXT && !sync_fall && !lost) ? loss_reg + 1'b1 : '0;
  assign fbp_next  = (mode_reg != M_FALLBK) ? 8'h00 : (per_hit ? fbp_reg + 8'h01 : fbp_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg   <= M_RT;
      sync_d_reg <= 1'b0;
      cnt_reg    <= '0;
      loss_reg   <= '0;
      fbp_reg    <= 8'h00;
      cyc_start  <= 1'b0;
      ext_mode   <= 1'b0;
      fallback   <= 1'b0;
      pin_drive  <= 1'b1;
    end else begin
      mode_reg   <= mode_next;
      sync_d_reg <= sync_lvl;
      cnt_reg    <= cnt_next;
      loss_reg   <= loss_next;
      fbp_reg    <= fbp_next;
      cyc_start  <= cyc_next;
      ext_mode   <= (mode_next == M_EXT);
      fallback   <= (mode_next == M_FALLBK);
      pin_drive  <= (mode_next == M_RT);
    end
  end

  ext_fall_a: assert property (@(posedge clk) disable iff (rst)
    (mode_reg == M_EXT && sync_fall) |=> cyc_start)
    else $error("ext falling edge gave no cycle start");

  enter_ext_a: assert property (@(posedge clk) disable iff (rst)
    (mode_reg == M_RT && sync_rise) |=> (ext_mode && !pin_drive))
    else $error("sync high did not enter ext mode");

  no_direct_rt_a: assert property (@(posedge clk) disable iff (rst)
    (mode_reg == M_EXT) |=> (mode_reg != M_RT))
    else $error("ext mode returned to rt without fallback");

endmodule

// ---- bfsc_pkg.sv ----
package bfsc_pkg;

  localparam int CLK_HZ        = 40_000_000;
  localparam int FALLBACK_HZ   = 100_000;
  localparam int SYNC_MIN_HZ   = 200_000;
  localparam int FALLBACK_CYC  = CLK_HZ / FALLBACK_HZ;
  localparam int SYNC_LOSS_CYC = 2 * (CLK_HZ / SYNC_MIN_HZ);
  localparam int FALLBACK_PULSES = 16;
  localparam int OVL_WAIT_CYC  = 512;
  localparam int OC_HICCUP_DEF = 16384;
  localparam int OT_HICCUP_DEF = 32768;
  localparam int TW            = 16;

  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_BLANK = 8'h04;
  localparam logic [7:0] A_RTPER = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0C;
  localparam logic [7:0] A_FAULT = 8'h10;

  localparam logic [15:0] RT_PER_RST = 16'h00C8;
  localparam logic [15:0] BLANK_RST  = 16'h0000;

  localparam int F_OC   = 0;
  localparam int F_OT   = 1;
  localparam int F_UV   = 2;
  localparam int F_OV   = 3;
  localparam int F_SRC  = 4;
  localparam int F_SINK = 5;
  localparam int NUM_F  = 6;

  localparam int IN_SYNC  = 0;
  localparam int IN_WIN   = 1;
  localparam int IN_FLO   = 2;
  localparam int IN_FHI   = 3;
  localparam int IN_OV    = 4;
  localparam int IN_PEAK  = 5;
  localparam int IN_SRC   = 6;
  localparam int IN_SINK  = 7;
  localparam int IN_NEG   = 8;
  localparam int IN_OVL   = 9;
  localparam int IN_OT    = 10;
  localparam int IN_EN    = 11;
  localparam int IN_UV    = 12;
  localparam int IN_BOOT  = 13;
  localparam int IN_SSZ   = 14;
  localparam int IN_SSTH  = 15;
  localparam int IN_SSREF = 16;
  localparam int IN_PGPIN = 17;
  localparam int NUM_IN   = 18;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_DISCH  = 3'b001,
    ST_RAMP   = 3'b010,
    ST_RUN    = 3'b011,
    ST_OCHIC  = 3'b100,
    ST_OTWAIT = 3'b101,
    ST_OTHIC  = 3'b110
  } bfsc_state_t;

  typedef enum logic [1:0] {
    M_RT     = 2'b00,
    M_EXT    = 2'b01,
    M_FALLBK = 2'b10
  } bfsc_mode_t;

endpackage

// ---- bfsc_sync_src.sv ----
`timescale 1ns/1ps
module bfsc_sync_src #(
  parameter realtime HALF = 1250.0
) (
  input  wire logic run,
  input  wire logic pg_oe,
  output logic      sync_lvl,
  output logic      pg_line
);
  // Stopped source idles low; odd start offset keeps it unrelated to CLK
  initial begin
    sync_lvl = 1'b0;
    #7.3;
    forever begin
      sync_lvl = run;
      #(HALF);
      sync_lvl = 1'b0;
      #(HALF);
    end
  end
  // Pull-up on the open-drain power ok line
  assign pg_line = pg_oe ? 1'b0 : 1'b1;
endmodule

// ---- bfsc_timer.sv ----
`timescale 1ns/1ps
module bfsc_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         step,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire          hit = (cnt_reg == limit);

  // Counter freezes at the limit so done stays up until cleared
  assign cnt_next = clr ? '0 : ((step && !hit) ? cnt_reg + 1'b1 : cnt_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      done    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done    <= !clr && (cnt_next == limit);
    end
  end

endmodule

// ---- bfsc_top.sv ----
// Notes on behaviour
// - Detect external clock; it overrides resistor oscillator
// - First sync high enters external mode, pin floats
// - External mode cycles start on falling edge
// - Lost clock: fallback rate first, then resistor rate
// - Reference is lower of ramp and internal
// - Lockout, disable or overheat stop switching
// - Restart waits for ramp discharged to ground
// - Release power ok inside feedback window
// - Pull power ok low outside fault limits
// - Force power ok low on shutdown, low ramp
// - Optional blanking of power ok pull-down
// - Boot undervoltage forces low-side refresh
// - Overvoltage keeps high-side switch off
// - High-side resumes only at next cycle start
// - Peak current ends high-side, starts low-side
// - Source limit at cycle end skips high-side
// - Sink limit turns both off until next cycle
// - Persistent overload shuts down, hiccup then restart
// - Overheat stops, hiccup after cooling, then restart
// - No low-side sinking before ramp threshold
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module bfsc_top import bfsc_pkg::*; #(
  parameter int OC_HICCUP = OC_HICCUP_DEF,
  parameter int OT_HICCUP = OT_HICCUP_DEF
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        FREQ_SET_SYNC_PIN_I,
  output logic             FREQ_SET_SYNC_PIN_O,
  output logic             FREQ_SET_SYNC_PIN_OE,
  input  wire logic        FEEDBACK_SENSE_IN_WIN,
  input  wire logic        FEEDBACK_SENSE_LOW_FAULT,
  input  wire logic        FEEDBACK_SENSE_HIGH_FAULT,
  input  wire logic        OVERVOLTAGE_GUARD_TRIP,
  input  wire logic        PEAK_CURRENT_REACHED,
  input  wire logic        LS_SOURCE_LIMIT,
  input  wire logic        LS_SINK_LIMIT,
  input  wire logic        LS_CURRENT_NEG,
  input  wire logic        OVERLOAD_COMP,
  input  wire logic        OVER_TEMP,
  input  wire logic        ENABLE_IN,
  input  wire logic        UNDERVOLTAGE_LOCKOUT,
  input  wire logic        BOOT_UNDERVOLTAGE,
  input  wire logic        RAMP_AT_GROUND,
  input  wire logic        RAMP_ABOVE_PG_TH,
  input  wire logic        RAMP_BELOW_REF,
  input  wire logic        POWER_OK_OUTPUT_I,
  output logic             POWER_OK_OUTPUT_O,
  output logic             POWER_OK_OUTPUT_OE,
  output logic             HS_GATE_ON,
  output logic             LS_GATE_ON,
  output logic             RAMP_DISCHARGE,
  output logic             REF_FROM_RAMP,
  output logic             CLK_MODE_ACTIVE
);

  // Two-stage synchronisers for all analog comparator results
  logic [NUM_IN-1:0] s1_reg;
  logic [NUM_IN-1:0] s2_reg;
  wire  [NUM_IN-1:0] in_raw;

  assign in_raw[IN_SYNC]  = FREQ_SET_SYNC_PIN_I;
  assign in_raw[IN_WIN]   = FEEDBACK_SENSE_IN_WIN;
  assign in_raw[IN_FLO]   = FEEDBACK_SENSE_LOW_FAULT;
  assign in_raw[IN_FHI]   = FEEDBACK_SENSE_HIGH_FAULT;
  assign in_raw[IN_OV]    = OVERVOLTAGE_GUARD_TRIP;
  assign in_raw[IN_PEAK]  = PEAK_CURRENT_REACHED;
  assign in_raw[IN_SRC]   = LS_SOURCE_LIMIT;
  assign in_raw[IN_SINK]  = LS_SINK_LIMIT;
  assign in_raw[IN_NEG]   = LS_CURRENT_NEG;
  assign in_raw[IN_OVL]   = OVERLOAD_COMP;
  assign in_raw[IN_OT]    = OVER_TEMP;
  assign in_raw[IN_EN]    = ENABLE_IN;
  assign in_raw[IN_UV]    = UNDERVOLTAGE_LOCKOUT;
  assign in_raw[IN_BOOT]  = BOOT_UNDERVOLTAGE;
  assign in_raw[IN_SSZ]   = RAMP_AT_GROUND;
  assign in_raw[IN_SSTH]  = RAMP_ABOVE_PG_TH;
  assign in_raw[IN_SSREF] = RAMP_BELOW_REF;
  assign in_raw[IN_PGPIN] = POWER_OK_OUTPUT_I;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= in_raw;
      s2_reg <= s1_reg;
    end
  end

  wire sync_s  = s2_reg[IN_SYNC];
  wire win_s   = s2_reg[IN_WIN];
  wire flo_s   = s2_reg[IN_FLO];
  wire fhi_s   = s2_reg[IN_FHI];
  wire ov_s    = s2_reg[IN_OV];
  wire peak_s  = s2_reg[IN_PEAK];
  wire src_s   = s2_reg[IN_SRC];
  wire sink_s  = s2_reg[IN_SINK];
  wire neg_s   = s2_reg[IN_NEG];
  wire ovl_s   = s2_reg[IN_OVL];
  wire ot_s    = s2_reg[IN_OT];
  wire en_s    = s2_reg[IN_EN];
  wire uv_s    = s2_reg[IN_UV];
  wire boot_s  = s2_reg[IN_BOOT];
  wire ssz_s   = s2_reg[IN_SSZ];
  wire ssth_s  = s2_reg[IN_SSTH];
  wire ssref_s = s2_reg[IN_SSREF];
  wire pgpin_s = s2_reg[IN_PGPIN];

  // Register file and bus slave state
  logic             int_mode_reg;
  logic [15:0]      blank_len_reg;
  logic [15:0]      rt_per_reg;
  logic [NUM_F-1:0] fault_reg;
  logic [NUM_F-1:0] fault_next;
  logic             wr_pend_reg;
  logic [7:0]       wa_reg;
  logic [31:0]      rd_mux;
  logic             const_lo_reg;

  function automatic logic at(input logic [7:0] a, input logic [7:0] b);
    at = (a == b);
  endfunction

  wire ahb_go      = HSEL & HTRANS[1] & HREADY;
  wire wr_ctrl     = wr_pend_reg & at(wa_reg, A_CTRL);
  wire wr_blank    = wr_pend_reg & at(wa_reg, A_BLANK);
  wire wr_rtper    = wr_pend_reg & at(wa_reg, A_RTPER);
  wire wr_fault    = wr_pend_reg & at(wa_reg, A_FAULT);
  wire blank_start = wr_blank & int_mode_reg;

  // Core state
  bfsc_state_t st_reg;
  bfsc_state_t st_next;
  logic        hs_reg;
  logic        hs_next;
  logic        ls_reg;
  logic        ls_next;
  logic        blk_reg;
  logic        blk_next;
  logic        pull_reg;
  logic        pull_next;
  logic        blank_run_reg;
  logic        ref_reg;
  logic        disch_reg;
  logic        cyc_start;
  logic        ext_mode;
  logic        fallback;
  logic        pin_drive;
  logic        ovl_done;
  logic        hic_done;
  logic        blank_done;

  wire stop      = uv_s | ~en_s | ot_s;
  wire switching = (st_reg == ST_RAMP) || (st_reg == ST_RUN);
  wire sw_on     = switching && !stop;
  wire hic_cnt   = (st_reg == ST_OCHIC) || (st_reg == ST_OTHIC);
  wire blank_act = blank_run_reg & ~blank_done;

  bfsc_cycgen #(
    .PW        (16)
  ) u_cycgen (
    .clk       (CLK),
    .rst       (SYS_RST),
    .sync_lvl  (sync_s),
    .rt_period (rt_per_reg),
    .cyc_start (cyc_start),
    .ext_mode  (ext_mode),
    .fallback  (fallback),
    .pin_drive (pin_drive)
  );

  // Overload must persist through consecutive cycles
  bfsc_timer #(
    .W     (TW)
  ) u_ovl_wait (
    .clk   (CLK),
    .rst   (SYS_RST),
    .clr   (!(ovl_s && switching)),
    .step  (cyc_start),
    .limit (TW'(OVL_WAIT_CYC)),
    .done  (ovl_done)
  );

  // One timer serves both hiccups since they never overlap
  bfsc_timer #(
    .W     (TW)
  ) u_hiccup (
    .clk   (CLK),
    .rst   (SYS_RST),
    .clr   (!hic_cnt),
    .step  (cyc_start),
    .limit ((st_reg == ST_OTHIC) ? TW'(OT_HICCUP) : TW'(OC_HICCUP)),
    .done  (hic_done)
  );

  bfsc_timer #(
    .W     (TW)
  ) u_blank (
    .clk   (CLK),
    .rst   (SYS_RST),
    .clr   (blank_start | ~blank_run_reg),
    .step  (cyc_start),
    .limit (blank_len_reg),
    .done  (blank_done)
  );

  // Sequencer: overheat outranks lockout and disable
  always_comb begin
    st_next = st_reg;
    if (ot_s) begin
      st_next = ST_OTWAIT;
    end else if (uv_s || !en_s) begin
      st_next = ST_OFF;
    end else begin
      unique case (st_reg)
        ST_OFF:    st_next = ST_DISCH;
        ST_DISCH:  if (ssz_s) st_next = ST_RAMP;
        ST_RAMP: begin
          if (ovl_done) st_next = ST_OCHIC;
          else if (ssth_s) st_next = ST_RUN;
        end
        ST_RUN:    if (ovl_done) st_next = ST_OCHIC;
        ST_OCHIC:  if (hic_done) st_next = ST_DISCH;
        ST_OTWAIT: st_next = ST_OTHIC;
        ST_OTHIC:  if (hic_done) st_next = ST_DISCH;
        default:   st_next = ST_OFF;
      endcase
    end
  end

  // Switch control; high side only ever rises at a cycle start
  always_comb begin
    hs_next  = hs_reg;
    ls_next  = ls_reg;
    blk_next = blk_reg;
    if (!sw_on) begin
      hs_next  = 1'b0;
      ls_next  = 1'b0;
      blk_next = 1'b0;
    end else if (cyc_start) begin
      blk_next = 1'b0;
      hs_next  = !src_s && !ov_s && !boot_s;
      ls_next  = !hs_next;
    end else begin
      if (hs_reg && (peak_s || ov_s || boot_s)) begin
        hs_next = 1'b0;
        ls_next = !blk_reg;
      end
      if (ls_reg && (sink_s || (neg_s && !ssth_s))) begin
        ls_next  = 1'b0;
        blk_next = 1'b1;
      end
    end
  end

  // Pull-down holds between limits, giving the hysteresis band
  wire pg_force = uv_s | ot_s | ~en_s | ~ssth_s | (st_reg != ST_RUN);
  wire pg_fault = (flo_s | fhi_s) & ~blank_act;
  assign pull_next = (pg_force | pg_fault) ? 1'b1 : (win_s ? 1'b0 : pull_reg);

  wire [NUM_F-1:0] fault_set;
  assign fault_set[F_OC]   = (st_next == ST_OCHIC) && (st_reg != ST_OCHIC);
  assign fault_set[F_OT]   = ot_s;
  assign fault_set[F_UV]   = uv_s;
  assign fault_set[F_OV]   = ov_s;
  assign fault_set[F_SRC]  = src_s & cyc_start & sw_on;
  assign fault_set[F_SINK] = sink_s & ls_reg;

  // A new event in the clearing cycle survives the clear
  assign fault_next = (fault_reg & ~(wr_fault ? HWDATA[NUM_F-1:0] : '0)) | fault_set;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg        <= ST_OFF;
      hs_reg        <= 1'b0;
      ls_reg        <= 1'b0;
      blk_reg       <= 1'b0;
      pull_reg      <= 1'b1;
      blank_run_reg <= 1'b0;
      ref_reg       <= 1'b1;
      disch_reg     <= 1'b1;
    end else begin
      st_reg        <= st_next;
      hs_reg        <= hs_next;
      ls_reg        <= ls_next;
      blk_reg       <= blk_next;
      pull_reg      <= pull_next;
      blank_run_reg <= int_mode_reg & (blank_start | (blank_run_reg & ~blank_done));
      ref_reg       <= ssref_s;
      disch_reg     <= (st_next != ST_RAMP) && (st_next != ST_RUN);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (HADDR[7:0])
      A_CTRL:  rd_mux = {31'h0000_0000, int_mode_reg};
      A_BLANK: rd_mux = {16'h0000, blank_len_reg};
      A_RTPER: rd_mux = {16'h0000, rt_per_reg};
      A_STAT:  rd_mux = {22'h00_0000, pgpin_s, blank_act, pull_reg, ls_reg, hs_reg,
                         fallback, ext_mode, st_reg};
      A_FAULT: rd_mux = {{(32-NUM_F){1'b0}}, fault_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: read data registered in the address phase
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wr_pend_reg   <= 1'b0;
      wa_reg        <= 8'h00;
      HRDATA        <= 32'h0000_0000;
      HREADYOUT     <= 1'b1;
      const_lo_reg  <= 1'b0;
      int_mode_reg  <= 1'b0;
      blank_len_reg <= BLANK_RST;
      rt_per_reg    <= RT_PER_RST;
      fault_reg     <= '0;
    end else begin
      wr_pend_reg   <= ahb_go & HWRITE;
      wa_reg        <= HADDR[7:0];
      HREADYOUT     <= 1'b1;
      const_lo_reg  <= 1'b0;
      if (ahb_go && !HWRITE) HRDATA <= rd_mux;
      if (wr_ctrl) int_mode_reg <= HWDATA[0];
      if (wr_blank) blank_len_reg <= HWDATA[15:0];
      if (wr_rtper) rt_per_reg <= HWDATA[15:0];
      fault_reg     <= fault_next;
    end
  end

  assign HRESP                = const_lo_reg;
  assign POWER_OK_OUTPUT_O    = const_lo_reg;
  assign POWER_OK_OUTPUT_OE   = pull_reg;
  assign HS_GATE_ON           = hs_reg;
  assign LS_GATE_ON           = ls_reg;
  assign RAMP_DISCHARGE       = disch_reg;
  assign REF_FROM_RAMP        = ref_reg;
  assign CLK_MODE_ACTIVE      = ext_mode;
  assign FREQ_SET_SYNC_PIN_O  = pin_drive;
  assign FREQ_SET_SYNC_PIN_OE = pin_drive;

  ov_hs_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    ov_s |=> !HS_GATE_ON)
    else $error("high side on during overvoltage");

  hs_rise_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    $rose(HS_GATE_ON) |-> $past(cyc_start))
    else $error("high side rose outside cycle start");

  peak_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (HS_GATE_ON && peak_s && !cyc_start && sw_on) |=> (!HS_GATE_ON && (LS_GATE_ON || blk_reg)))
    else $error("peak current did not end high side");

  src_skip_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (cyc_start && src_s) |=> (!HS_GATE_ON ##1 !HS_GATE_ON || $past(cyc_start)))
    else $error("source limit did not skip pulse");

  sink_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (LS_GATE_ON && sink_s && !cyc_start) |=> (!LS_GATE_ON && !HS_GATE_ON))
    else $error("sink limit did not stop low side");

  stop_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    stop |=> (!HS_GATE_ON && !LS_GATE_ON && RAMP_DISCHARGE))
    else $error("switching during shutdown");

  ramp_entry_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (st_reg == ST_RAMP && $past(st_reg) != ST_RAMP) |-> $past(ssz_s))
    else $error("ramp began without discharge");

  pg_force_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    pg_force |=> POWER_OK_OUTPUT_OE)
    else $error("power ok not forced low");

  pg_release_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!pg_force && !pg_fault && win_s) |=> !POWER_OK_OUTPUT_OE)
    else $error("power ok not released in window");

  ovl_hiccup_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (switching && ovl_done && !stop) |=> (st_reg == ST_OCHIC))
    else $error("overload did not enter hiccup");

endmodule

// ---- bfsc_top_tb.sv ----
`timescale 1ns/1ps
module bfsc_top_tb import bfsc_pkg::*; ;
  localparam int OCH = 20;
  localparam int OTH = 30;
  logic        CLK = 1'b0, SYS_RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, HREADY;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q;
  logic        HREADYOUT, HRESP, FREQ_SET_SYNC_PIN_I, FREQ_SET_SYNC_PIN_O, FREQ_SET_SYNC_PIN_OE;
  logic        FEEDBACK_SENSE_IN_WIN = 1'b0, FEEDBACK_SENSE_LOW_FAULT = 1'b0;
  logic        FEEDBACK_SENSE_HIGH_FAULT = 1'b0, OVERVOLTAGE_GUARD_TRIP = 1'b0;
  logic        PEAK_CURRENT_REACHED = 1'b0, LS_SOURCE_LIMIT = 1'b0, LS_SINK_LIMIT = 1'b0;
  logic        LS_CURRENT_NEG = 1'b0, OVERLOAD_COMP = 1'b0, OVER_TEMP = 1'b0, ENABLE_IN = 1'b0;
  logic        UNDERVOLTAGE_LOCKOUT = 1'b0, BOOT_UNDERVOLTAGE = 1'b0, RAMP_AT_GROUND = 1'b0;
  logic        RAMP_ABOVE_PG_TH = 1'b0, RAMP_BELOW_REF = 1'b1, POWER_OK_OUTPUT_I;
  logic        POWER_OK_OUTPUT_O, POWER_OK_OUTPUT_OE, HS_GATE_ON, LS_GATE_ON;
  logic        RAMP_DISCHARGE, REF_FROM_RAMP, CLK_MODE_ACTIVE, sync_run = 1'b0, seen;
  int          n_fail = 0, checked = 0, rt, k;

  assign HREADY = HREADYOUT;
  always #12.5 CLK = ~CLK;

  bfsc_top #(.OC_HICCUP(OCH), .OT_HICCUP(OTH)) i_bfsc_top (.*);
  bfsc_sync_src i_bfsc_sync_src (.run(sync_run), .pg_oe(POWER_OK_OUTPUT_OE),
    .sync_lvl(FREQ_SET_SYNC_PIN_I), .pg_line(POWER_OK_OUTPUT_I));

  task give_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Single word transfer; address and data phase each held until ready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HSIZE <= 3'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    q = HRDATA;
  endtask

  // Poll status until the masked field matches, bounded
  task poll(input logic [31:0] m, input logic [31:0] v, input int lim);
    k = 0;
    bus(1'b0, A_STAT, 32'h0);
    while ((q & m) !== v && k < lim) begin
      bus(1'b0, A_STAT, 32'h0);
      k++;
    end
    chk("status", v, q & m);
  endtask

  task tick(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task blk(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge CLK);
      if (HS_GATE_ON !== 1'b0) seen = 1'b1;
    end
    chk("hs_blocked", 32'h0, {31'h0, seen});
  endtask

  task hs_up(input int lim);
    k = 0;
    while (HS_GATE_ON !== 1'b1 && k < lim) begin
      @(posedge CLK);
      k++;
    end
    chk("hs_up", 32'h1, {31'h0, HS_GATE_ON});
  endtask

  initial begin
    // Long enough for every wait below; the overload ticks of 300 and 500 times rt dominate
    #(25.0 * 90000);
    n_fail++;
    give_verdict;
  end

  initial begin
    void'($urandom(2336));
    rt = 8 + $urandom % 8;
    tick(8);
    SYS_RST <= 1'b0;
    tick(1);
    bus(1'b0, A_RTPER, 32'h0);
    chk("rt_reset", 32'h00C8, q);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, {31'h0, HRESP});
    bus(1'b1, A_RTPER, rt);
    bus(1'b0, A_RTPER, 32'h0);
    chk("rt_period", rt, q);
    ENABLE_IN <= 1'b1;
    FEEDBACK_SENSE_IN_WIN <= 1'b1;
    poll(32'h7, 32'h1, 50);
    chk("disch", 32'h1, {31'h0, RAMP_DISCHARGE});
    tick(20);
    poll(32'h7, 32'h1, 0);
    chk("pg_ramp_low", 32'h1, POWER_OK_OUTPUT_OE);
    RAMP_AT_GROUND <= 1'b1;
    poll(32'h7, 32'h2, 50);
    RAMP_ABOVE_PG_TH <= 1'b1;
    poll(32'h7, 32'h3, 50);
    tick(4);
    chk("disch_run", 32'h0, {31'h0, RAMP_DISCHARGE});
    chk("pg_release", 32'h1, POWER_OK_OUTPUT_I);
    FEEDBACK_SENSE_IN_WIN <= 1'b0;
    FEEDBACK_SENSE_LOW_FAULT <= 1'b1;
    tick(4);
    chk("pg_fault", 32'h1, POWER_OK_OUTPUT_OE);
    FEEDBACK_SENSE_LOW_FAULT <= 1'b0;
    FEEDBACK_SENSE_IN_WIN <= 1'b1;
    RAMP_BELOW_REF <= 1'b0;
    tick(4);
    chk("ref_sel", 32'h0, REF_FROM_RAMP);
    hs_up(4 * rt);
    PEAK_CURRENT_REACHED <= 1'b1;
    tick(4);
    chk("peak_hs", 32'h0, HS_GATE_ON);
    chk("peak_ls", 32'h1, LS_GATE_ON);
    LS_SINK_LIMIT <= 1'b1;
    tick(4);
    chk("sink_ls", 32'h0, {31'h0, LS_GATE_ON});
    LS_SINK_LIMIT <= 1'b0;
    bus(1'b0, A_FAULT, 32'h0);
    chk("fault_sink", 32'h20, q);
    tick(4);
    bus(1'b1, A_FAULT, 32'h3F);
    bus(1'b0, A_FAULT, 32'h0);
    chk("fault_clr", 32'h0, q);
    PEAK_CURRENT_REACHED <= 1'b0;
    BOOT_UNDERVOLTAGE <= 1'b1;
    tick(4);
    blk(3 * rt);
    BOOT_UNDERVOLTAGE <= 1'b0;
    OVERVOLTAGE_GUARD_TRIP <= 1'b1;
    tick(4);
    blk(3 * rt);
    OVERVOLTAGE_GUARD_TRIP <= 1'b0;
    sync_run <= 1'b1;
    poll(32'h8, 32'h8, 200);
    chk("pin_float", 32'h0, FREQ_SET_SYNC_PIN_OE);
    chk("ext_out", 32'h1, {31'h0, CLK_MODE_ACTIVE});
    PEAK_CURRENT_REACHED <= 1'b1;
    @(negedge FREQ_SET_SYNC_PIN_I);
    @(posedge CLK);
    PEAK_CURRENT_REACHED <= 1'b0;
    hs_up(20);
    chk("edge_start", 32'h1, {31'h0, k >= 2 && k <= 6});
    sync_run <= 1'b0;
    poll(32'h10, 32'h10, 300);
    chk("fb_float", 32'h0, FREQ_SET_SYNC_PIN_OE);
    chk("fb_out", 32'h0, {31'h0, CLK_MODE_ACTIVE});
    poll(32'h18, 32'h0, 4000);
    chk("rt_drive", 32'h1, FREQ_SET_SYNC_PIN_OE);
    OVERLOAD_COMP <= 1'b1;
    tick(300 * rt);
    OVERLOAD_COMP <= 1'b0;
    tick(3 * rt);
    OVERLOAD_COMP <= 1'b1;
    tick(500 * rt);
    poll(32'h7, 32'h3, 0);
    poll(32'h7, 32'h4, 100);
    OVERLOAD_COMP <= 1'b0;
    RAMP_AT_GROUND <= 1'b0;
    tick(OCH * rt - 20);
    poll(32'h7, 32'h4, 0);
    poll(32'h7, 32'h1, 100);
    RAMP_AT_GROUND <= 1'b1;
    poll(32'h7, 32'h3, 50);
    OVER_TEMP <= 1'b1;
    poll(32'h7, 32'h5, 20);
    chk("ot_gates", 32'h0, {30'h0, HS_GATE_ON, LS_GATE_ON});
    RAMP_AT_GROUND <= 1'b0;
    OVER_TEMP <= 1'b0;
    poll(32'h7, 32'h6, 20);
    tick(OTH * rt - 20);
    poll(32'h7, 32'h6, 0);
    poll(32'h7, 32'h1, 100);
    RAMP_AT_GROUND <= 1'b1;
    poll(32'h7, 32'h3, 50);
    ENABLE_IN <= 1'b0;
    poll(32'h7, 32'h0, 20);
    chk("off_gates", 32'h0, {30'h0, HS_GATE_ON, LS_GATE_ON});
    chk("off_pg", 32'h1, POWER_OK_OUTPUT_OE);
    give_verdict;
  end
endmodule
